// File: hrf_pkg.sv
/*
 * Constants for the receive header filter: register offsets, reset values
 * and widths.
 * Assumes a byte-wide register port with a 7-bit address.
 */
package hrf_pkg;
    localparam int unsigned AddrWidth = 7;
    localparam int unsigned HdrWidth = 32;
    localparam int unsigned ByteLanes = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] CheckHeaderB3Addr = 7'h3f;
    localparam logic [6:0] CheckHeaderB2Addr = 7'h40;
    localparam logic [6:0] CheckHeaderB1Addr = 7'h41;
    localparam logic [6:0] CheckHeaderB0Addr = 7'h42;
    localparam logic [6:0] CompareMaskB3Addr = 7'h43;
    localparam logic [6:0] CompareMaskB2Addr = 7'h44;
    localparam logic [6:0] CompareMaskB1Addr = 7'h45;
    localparam logic [6:0] CompareMaskB0Addr = 7'h46;
    localparam logic [6:0] ReceivedHeaderB3Addr = 7'h47;
    localparam logic [6:0] ReceivedHeaderB2Addr = 7'h48;
    localparam logic [6:0] ReceivedHeaderB1Addr = 7'h49;
    localparam logic [6:0] ReceivedHeaderB0Addr = 7'h4a;
    localparam logic [6:0] ReceivedLengthAddr = 7'h4b;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CheckHeaderReset = 32'h0000_0000;
    localparam logic [31:0] CompareMaskReset = 32'h0000_0000;
    localparam logic [31:0] ReceivedHeaderReset = 32'h0000_0000;
    localparam logic [7:0] ReceivedLengthReset = 8'hff;
    localparam logic [7:0] UnmappedReadValue = 8'h00;
endpackage

// File: hrf_cmp_if.sv
/*
 * Carrier between the register file and the header comparator.
 * Assumes both ends share the block clock.
 */
`timescale 1ns/1ps
interface hrf_cmp_if;
    logic [31:0] checkHeader;
    logic [31:0] compareMask;
    logic [31:0] rxHeader;
    logic [3:0] byteCheckEn;
    logic match;

    modport regs
    (
        output checkHeader,
        output compareMask,
        output rxHeader,
        output byteCheckEn,
        input match
    );
    modport cmp
    (
        input checkHeader,
        input compareMask,
        input rxHeader,
        input byteCheckEn,
        output match
    );
endinterface

// File: hrf_hdr_compare.sv
/*
 * Masked comparison of a received header against the check header.
 * Assumes inputs are stable in the cycle the result is sampled.
 */
`timescale 1ns/1ps
module hrf_hdr_compare
(
    hrf_cmp_if.cmp cmp
);
    logic [31:0] bitMismatch;
    logic [3:0] laneMismatch;

    // Only bits whose mask bit is one can disagree.
    assign bitMismatch = (cmp.checkHeader ^ cmp.rxHeader) & cmp.compareMask;

    genvar lane;
    generate
        for (lane = 0; lane < hrf_pkg::ByteLanes; lane++)
        begin : gLane
            // A lane whose byte check is disabled never rejects.
            assign laneMismatch[lane] = cmp.byteCheckEn[lane]
                & (|bitMismatch[lane*8 +: 8]);
        end
    endgenerate

    assign cmp.match = ~(|laneMismatch);
endmodule

// File: hrf_rx_header_filter.sv
/*
 * Receive header filter: check header and compare mask registers,
 * captured header and length of the last packet, and the match result.
 * A length byte that arrives while fixed-length mode is on is dropped, so
 * 4Bh keeps the length of the last variable-length packet.
 * Host writes to the received header and length offsets change nothing,
 * and neither do writes outside 3Fh to 4Bh; reads out there return zero.
 * The header verdict stands until the next header strobe replaces it.
 * Assumes the packet stream presents the header and the length byte as
 * one-cycle strobes synchronous to ref_clk, and that fixed-length mode,
 * configured length and byte check enables come from neighbouring logic.
 */
// What this block does
// - Compare check header with received header only where the mask bit is one.
// - Four byte-wide mask registers form the 32-bit compare mask.
// - Check header bytes sit at 3Fh-42h, read/write, reset to zero.
// - Mask bytes sit at 43h-46h, most significant first, reset to zero.
// - Received header captured into read-only bytes 47h (MSB) to 4Ah (LSB).
// - Host writes to received header bytes change nothing.
// - In variable-length mode store the received length byte, read-only.
// - Received length is only meaningful when fixed-length mode is off.
// - Received length resets to all ones.
// - Fixed-length mode uses the configured length as expected length.
// - Comparison applies only where header checking is enabled.
`timescale 1ns/1ps
module hrf_rx_header_filter
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [6:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic rxHeaderValid,
    input wire logic [31:0] rxHeaderWord,
    input wire logic rxLengthValid,
    input wire logic [7:0] rxLengthByte,
    input wire logic fixedLengthMode,
    input wire logic [7:0] configuredLength,
    input wire logic [3:0] headerCheckEn,
    output logic headerDone,
    output logic headerMatch,
    output logic [7:0] expectedLength
);
    logic [31:0] checkHeader_reg;
    logic [31:0] compareMask_reg;
    logic [31:0] receivedHeader_reg;
    logic [7:0] receivedLength_reg;
    logic [7:0] regRdData_next;
    logic lengthByteTaken;

    hrf_cmp_if cmpBus();

    // ------------------------------------------------------------
    // Host-writable configuration
    // ------------------------------------------------------------
    // Writes to the received fields and to unmapped offsets fall to the default arm.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            checkHeader_reg <= hrf_pkg::CheckHeaderReset;
        end
        else if (regWrEn)
        begin
            unique case (regAddr)
                hrf_pkg::CheckHeaderB3Addr: checkHeader_reg[31:24] <= regWrData;
                hrf_pkg::CheckHeaderB2Addr: checkHeader_reg[23:16] <= regWrData;
                hrf_pkg::CheckHeaderB1Addr: checkHeader_reg[15:8] <= regWrData;
                hrf_pkg::CheckHeaderB0Addr: checkHeader_reg[7:0] <= regWrData;
                default: checkHeader_reg <= checkHeader_reg;
            endcase
        end
    end

    // Zero mask after reset means nothing is compared until software asks.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            compareMask_reg <= hrf_pkg::CompareMaskReset;
        end
        else if (regWrEn)
        begin
            unique case (regAddr)
                hrf_pkg::CompareMaskB3Addr: compareMask_reg[31:24] <= regWrData;
                hrf_pkg::CompareMaskB2Addr: compareMask_reg[23:16] <= regWrData;
                hrf_pkg::CompareMaskB1Addr: compareMask_reg[15:8] <= regWrData;
                hrf_pkg::CompareMaskB0Addr: compareMask_reg[7:0] <= regWrData;
                default: compareMask_reg <= compareMask_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Captured packet fields
    // ------------------------------------------------------------
    // Only the packet stream loads these; the register port has no path in.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            receivedHeader_reg <= hrf_pkg::ReceivedHeaderReset;
        end
        else if (rxHeaderValid)
        begin
            receivedHeader_reg <= rxHeaderWord;
        end
    end

    // Length bytes seen in fixed-length mode belong to no field and are dropped.
    assign lengthByteTaken = rxLengthValid && !fixedLengthMode;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            receivedLength_reg <= hrf_pkg::ReceivedLengthReset;
        end
        else if (lengthByteTaken)
        begin
            receivedLength_reg <= rxLengthByte;
        end
    end

    // A fixed-length packet carries no length byte, so the configured value
    // stands in for it; the host must read it from there as well.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            expectedLength <= hrf_pkg::ReceivedLengthReset;
        end
        else if (fixedLengthMode)
        begin
            expectedLength <= configuredLength;
        end
        else if (rxLengthValid)
        begin
            expectedLength <= rxLengthByte;
        end
    end

    // ------------------------------------------------------------
    // Header comparison
    // ------------------------------------------------------------
    // The incoming word is compared directly so the verdict is ready one
    // edge after the strobe, together with the captured header.
    assign cmpBus.checkHeader = checkHeader_reg;
    assign cmpBus.compareMask = compareMask_reg;
    assign cmpBus.rxHeader = rxHeaderWord;
    assign cmpBus.byteCheckEn = headerCheckEn;

    hrf_hdr_compare uCompare
    (
        .cmp(cmpBus.cmp)
    );

    // Done marks every header, even one whose byte checks are all disabled.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            headerDone <= 1'b0;
        end
        else
        begin
            headerDone <= rxHeaderValid;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            headerMatch <= 1'b0;
        end
        else if (rxHeaderValid)
        begin
            headerMatch <= cmpBus.match;
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    // In fixed-length mode 4Bh keeps a stale value; the host takes the length
    // from the configured register instead.
    always_comb
    begin
        unique case (regAddr)
            hrf_pkg::CheckHeaderB3Addr: regRdData_next = checkHeader_reg[31:24];
            hrf_pkg::CheckHeaderB2Addr: regRdData_next = checkHeader_reg[23:16];
            hrf_pkg::CheckHeaderB1Addr: regRdData_next = checkHeader_reg[15:8];
            hrf_pkg::CheckHeaderB0Addr: regRdData_next = checkHeader_reg[7:0];
            hrf_pkg::CompareMaskB3Addr: regRdData_next = compareMask_reg[31:24];
            hrf_pkg::CompareMaskB2Addr: regRdData_next = compareMask_reg[23:16];
            hrf_pkg::CompareMaskB1Addr: regRdData_next = compareMask_reg[15:8];
            hrf_pkg::CompareMaskB0Addr: regRdData_next = compareMask_reg[7:0];
            hrf_pkg::ReceivedHeaderB3Addr: regRdData_next = receivedHeader_reg[31:24];
            hrf_pkg::ReceivedHeaderB2Addr: regRdData_next = receivedHeader_reg[23:16];
            hrf_pkg::ReceivedHeaderB1Addr: regRdData_next = receivedHeader_reg[15:8];
            hrf_pkg::ReceivedHeaderB0Addr: regRdData_next = receivedHeader_reg[7:0];
            hrf_pkg::ReceivedLengthAddr: regRdData_next = receivedLength_reg;
            default: regRdData_next = hrf_pkg::UnmappedReadValue;
        endcase
    end

    // Read data holds between reads so a slow host can sample at leisure.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            regRdData <= hrf_pkg::UnmappedReadValue;
        end
        else if (regRdEn)
        begin
            regRdData <= regRdData_next;
        end
    end
endmodule

// File: hrf_rx_header_filter_monitor.sv
/* Port checker for the receive header filter.
   Assumes it is bound to hrf_rx_header_filter. */
`timescale 1ns/1ps
module hrf_rx_header_filter_monitor
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [6:0] regAddr,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic rxHeaderValid,
    input wire logic rxLengthValid,
    input wire logic [7:0] rxLengthByte,
    input wire logic fixedLengthMode,
    input wire logic [7:0] configuredLength,
    input wire logic [3:0] headerCheckEn,
    input wire logic headerDone,
    input wire logic headerMatch,
    input wire logic [7:0] expectedLength
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    property p_done; rxHeaderValid |=> headerDone; endproperty
    a_done: assert property (p_done) else $error("done late");
    property p_pulse; headerDone && !rxHeaderValid |=> !headerDone; endproperty
    a_pulse: assert property (p_pulse) else $error("done stuck");
    property p_hold; !rxHeaderValid |=> $stable(headerMatch); endproperty
    a_hold: assert property (p_hold) else $error("match moved");
    property p_open; rxHeaderValid && headerCheckEn == 4'h0 |=> headerMatch; endproperty
    a_open: assert property (p_open) else $error("check not off");
    property p_fix;
        fixedLengthMode |=> expectedLength == $past(configuredLength);
    endproperty
    a_fix: assert property (p_fix) else $error("fixed length");
    property p_var;
        rxLengthValid && !fixedLengthMode |=> expectedLength == $past(rxLengthByte);
    endproperty
    a_var: assert property (p_var) else $error("length byte");
    property p_unmap;
        regRdEn && (regAddr < 7'h3f || regAddr > 7'h4b) |=> regRdData == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_rdhold; !regRdEn |=> $stable(regRdData); endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data moved");
    c_match: cover property (rxHeaderValid ##1 headerMatch);
    c_miss: cover property (rxHeaderValid ##1 !headerMatch);
    c_fix: cover property (fixedLengthMode && rxLengthValid);
endmodule
bind hrf_rx_header_filter hrf_rx_header_filter_monitor mon (.ref_clk, .rst, .regAddr,
    .regRdEn, .regRdData, .rxHeaderValid, .rxLengthValid, .rxLengthByte,
    .fixedLengthMode, .configuredLength, .headerCheckEn, .headerDone, .headerMatch,
    .expectedLength);

// File: hrf_host_model.sv
/* Host model: byte register writes and reads.
   Assumes strobes are taken on ref_clk rising edges. */
`timescale 1ns/1ps
module hrf_host_model
(
    input wire logic ref_clk,
    input wire logic [7:0] regRdData,
    output logic [6:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn
);
    initial
    begin
        regAddr = 7'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    // Idle lines carry the inverse, so stale values never pass for data.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #2;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge ref_clk);
        #2;
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #2;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge ref_clk);
        #2;
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
    endtask
    function automatic logic [7:0] rxCount(logic fixed, logic [7:0] cfg, logic [7:0] got);
        return fixed ? cfg : got;
    endfunction
endmodule

// File: tb_hrf_rx_header_filter.sv
/* Self-checking bench for the receive header filter.
   Assumes the port checker is bound in by its own file. */
`timescale 1ns/1ps
module tb_hrf_rx_header_filter;
    logic ref_clk, rst, regWrEn, regRdEn, rxHeaderValid, rxLengthValid;
    logic fixedLengthMode, headerDone, headerMatch;
    logic [6:0] regAddr;
    logic [7:0] regWrData, regRdData, rxLengthByte, configuredLength, expectedLength, rdv;
    logic [31:0] rxHeaderWord;
    logic [3:0] headerCheckEn;
    int miscompares = 0;
    int checksDone = 0;
    hrf_rx_header_filter DUT (.ref_clk, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn,
        .regRdData, .rxHeaderValid, .rxHeaderWord, .rxLengthValid, .rxLengthByte,
        .fixedLengthMode, .configuredLength, .headerCheckEn, .headerDone, .headerMatch,
        .expectedLength);
    hrf_host_model host (.ref_clk, .regRdData, .regAddr, .regWrData, .regWrEn, .regRdEn);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Fields are split big-endian: the lowest address holds bits 31:24.
    task automatic wr32(input logic [6:0] base, input logic [31:0] v);
        for (int i = 0; i < 4; i++)
            host.wr(base + 7'(i), v[31 - 8 * i -: 8]);
    endtask
    task automatic rd32(input string what, input logic [6:0] base, input logic [31:0] v);
        logic [7:0] d;
        for (int i = 0; i < 4; i++)
        begin
            host.rd(base + 7'(i), d);
            check(what, 32'(d), 32'(v[31 - 8 * i -: 8]));
        end
    endtask
    task automatic pkt(input logic [31:0] w, input logic exp);
        @(posedge ref_clk);
        #2;
        rxHeaderWord = w;
        rxHeaderValid = 1'b1;
        @(posedge ref_clk);
        #2;
        rxHeaderValid = 1'b0;
        rxHeaderWord = ~w;
        check("done", 32'(headerDone), 32'h1);
        check("match", 32'(headerMatch), 32'(exp));
    endtask
    task automatic len(input logic [7:0] b);
        @(posedge ref_clk);
        #2;
        rxLengthByte = b;
        rxLengthValid = 1'b1;
        @(posedge ref_clk);
        #2;
        rxLengthValid = 1'b0;
        rxLengthByte = ~b;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        finalReport();
    end
    initial
    begin
        rst = 1'b1;
        rxHeaderValid = 1'b0;
        rxHeaderWord = 32'h0;
        rxLengthValid = 1'b0;
        rxLengthByte = 8'h00;
        fixedLengthMode = 1'b0;
        configuredLength = 8'h00;
        headerCheckEn = 4'hf;
        repeat (8) @(posedge ref_clk);
        #2;
        rst = 1'b0;
        rd32("chk0", 7'h3f, 32'h0);
        rd32("mask0", 7'h43, 32'h0);
        rd32("rx0", 7'h47, 32'h0);
        host.rd(7'h4b, rdv);
        check("len0", 32'(rdv), 32'hff);
        $display("test reset done");
        wr32(7'h3f, 32'h8421_c3a5);
        wr32(7'h43, 32'h00ff_0f00);
        rd32("chk", 7'h3f, 32'h8421_c3a5);
        rd32("mask", 7'h43, 32'h00ff_0f00);
        host.rd(7'h50, rdv);
        check("unmap", 32'(rdv), 32'h0);
        $display("test map done");
        pkt(32'h5a21_f3ff, 1'b1);
        rd32("rx", 7'h47, 32'h5a21_f3ff);
        wr32(7'h47, 32'h0);
        rd32("rxro", 7'h47, 32'h5a21_f3ff);
        pkt(32'h8420_c3a5, 1'b0);
        pkt(32'h8421_c2a5, 1'b0);
        headerCheckEn = 4'hb;
        pkt(32'h8420_c3a5, 1'b1);
        headerCheckEn = 4'h0;
        pkt(32'h8421_c2a5, 1'b1);
        headerCheckEn = 4'hf;
        rd32("rxnew", 7'h47, 32'h8421_c2a5);
        $display("test compare done");
        len(8'h21);
        host.rd(7'h4b, rdv);
        check("len", 32'(rdv), 32'h21);
        check("exp", 32'(expectedLength), 32'h21);
        fixedLengthMode = 1'b1;
        configuredLength = 8'h40;
        len(8'h33);
        host.rd(7'h4b, rdv);
        check("lenfix", 32'(rdv), 32'h21);
        check("expfix", 32'(expectedLength), 32'(host.rxCount(1'b1, 8'h40, rdv)));
        $display("test length done");
        finalReport();
    end
endmodule
